/* rtl/host_bus_port_defs.svh */
`ifndef HOST_BUS_PORT_DEFS_SVH
`define HOST_BUS_PORT_DEFS_SVH

// Bus and address widths
`define DATA_W          8
`define MUX_ADDR_W      8
`define LOW_ADDR_W      6

// Clock rate in kHz
`define CLK_KHZ         250000

// Length of the reset pulse driven out, in milliseconds
`define RST_PULSE_MS    4
`define RST_PULSE_CYC   (`RST_PULSE_MS * `CLK_KHZ)
`define RST_CNT_W       20

// Read/write line level that marks a read (combined style)
`define RW_READ_LVL     1'b1

// Pin levels at reset: deselected, strobes high, latch strobe low,
// wake high, so release shows no false access and no false wake edge
`define PINS_IDLE       19'h74000

`endif

/* rtl/host_bus_port_pkg.sv */
package host_bus_port_pkg;

    // Filtered view of every bus pin input
    typedef struct packed {
        logic       cs_n;   // Chip select, low selects
        logic       rw;     // Read/write, or write strobe (low)
        logic       ds;     // Access end strobe, or read strobe (low)
        logic       ale;    // Address latch strobe
        logic       wake;   // External wake input
        logic [7:0] bus;    // Shared bus lines
        logic [5:0] addr;   // Low address lines
    } pins_t;

    // One register access handed to the core
    typedef struct packed {
        logic       write;  // 1 write, 0 read
        logic [7:0] addr;   // Register address
        logic [7:0] wdata;  // Write data
    } req_t;

    // Access state
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } acc_state_t;

endpackage

/* rtl/subscriber_ctrl_host_bus_port.sv */
// Behaviour
// R1 - Multiplexed: shared lines carry address, then data
// R2 - Non-multiplexed: shared lines carry data only
// R3 - Non-multiplexed: address on six low lines
// R4 - Act only while chip select is low
// R5 - Combined style: read/write high reads, low writes
// R6 - Combined style: strobe rising edge ends access
// R7 - Separate style: direction from whichever strobe asserted
// R8 - Open-drain interrupt low while interrupt pending
// R9 - Latch strobe high marks address, captured
// R10 - Latch strobe selects multiplexed or not
// R11 - Reset high forces reset; held long enough
// R12 - Terminal functions enabled: drive reset line out
// R13 - Wake falling edge: interrupt, optional reset pulse
// R14 - Drive data lines only during selected read
`timescale 1ns/10ps
`include "host_bus_port_defs.svh"

module subscriber_ctrl_host_bus_port
    import host_bus_port_pkg::*;
#(
    parameter int unsigned RST_PULSE_CYCLES = `RST_PULSE_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   sep_strobes,
    input  wire logic                   cs_n,
    input  wire logic                   rw_or_wr_n,
    input  wire logic                   access_end_strobe,
    input  wire logic                   ale,
    input  wire logic [`DATA_W-1:0]     mux_bus_lines_i,
    output      logic [`DATA_W-1:0]     mux_bus_lines_o,
    output      logic                   mux_bus_lines_oe,
    input  wire logic [`LOW_ADDR_W-1:0] low_addr_lines,
    output      logic                   irq_n_o,
    output      logic                   irq_n_oe,
    input  wire logic                   irq_pending,
    input  wire logic                   wake_input,
    input  wire logic                   wake_flag_clear,
    output      logic                   wake_flag,
    input  wire logic                   term_fn_en,
    input  wire logic                   rst_out_en,
    output      logic                   rst_line_o,
    output      logic                   rst_line_oe,
    output      logic                   reg_req_valid,
    output      req_t                   reg_req,
    input  wire logic [`DATA_W-1:0]     reg_rdata,
    output      logic                   mux_mode
);

    // Access is on: selected and a strobe active
    function automatic logic acc_on(input pins_t p, input logic sep);
        if (sep) begin
            acc_on = !p.cs_n && (!p.rw || !p.ds);
        end else begin
            acc_on = !p.cs_n && !p.ds;
        end
    endfunction

    // Access direction: 1 for a read
    function automatic logic acc_rd(input pins_t p, input logic sep);
        if (sep) begin
            acc_rd = !p.ds;
        end else begin
            acc_rd = (p.rw == `RW_READ_LVL);
        end
    endfunction

    pins_t      raw;            // Pins gathered
    pins_t      s1_ff;          // First stage, read only by s2
    pins_t      s2_ff;          // Second stage
    pins_t      s3_ff;          // Third stage
    pins_t      filt_ff;        // Settled pin levels
    logic       ale_d_ff;       // Latch strobe, one cycle ago
    logic       wake_d_ff;      // Wake input, one cycle ago
    logic       mux_mode_ff;    // Multiplexed style seen
    logic [7:0] ale_addr_ff;    // Address from address phase
    acc_state_t state_ff;       // Access state
    logic       req_valid_ff;   // Request pulse to core
    req_t       req_ff;         // Request contents
    logic [7:0] bus_out_ff;     // Read data driven out
    logic       bus_oe_ff;      // Drive enable for data lines
    logic       irq_oe_ff;      // Interrupt pin pulled low
    logic       wake_flag_ff;   // Wake event pending
    logic [`RST_CNT_W-1:0] rst_cnt_ff; // Reset pulse remaining
    logic       on;             // Access active now
    logic       rd;             // Access is a read
    logic       wake_fall;      // Settled wake falling edge
    logic [7:0] cur_addr;       // Address for this access

    assign raw = '{cs_n: cs_n, rw: rw_or_wr_n, ds: access_end_strobe,
                   ale: ale, wake: wake_input, bus: mux_bus_lines_i,
                   addr: low_addr_lines};

    // Three-stage synchroniser on all pin inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin  // R11
            // Idle levels: zeros would look like a selected strobe
            s1_ff <= pins_t'(`PINS_IDLE);
            s2_ff <= pins_t'(`PINS_IDLE);
            s3_ff <= pins_t'(`PINS_IDLE);
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A bit only changes once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_ff <= pins_t'(`PINS_IDLE);
        end else begin
            filt_ff <= pins_t'((~(s2_ff ^ s3_ff) & s2_ff) |
                               ((s2_ff ^ s3_ff) & filt_ff));
        end
    end

    assign on        = acc_on(filt_ff, sep_strobes);      // R4
    assign rd        = acc_rd(filt_ff, sep_strobes);      // R5 R7
    assign wake_fall = wake_d_ff && !filt_ff.wake;
    // Mux style takes latched address, else six low lines
    assign cur_addr  = mux_mode_ff ? ale_addr_ff :        // R1
                       {2'h0, filt_ff.addr};              // R2 R3

    // Edge history for latch strobe and wake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ale_d_ff  <= 1'b0;
            wake_d_ff <= 1'b1;
        end else begin
            ale_d_ff  <= filt_ff.ale;
            wake_d_ff <= filt_ff.wake;
        end
    end

    // Any latch strobe pulse switches to multiplexed style
    // Limitation: a strobe tied high still selects multiplexed, through its rise after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mux_mode_ff <= 1'b0;
        end else if (filt_ff.ale && !ale_d_ff) begin
            mux_mode_ff <= 1'b1;                          // R10
        end
    end

    // Address phase: capture shared lines while strobe high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ale_addr_ff <= 8'h00;
        end else if (filt_ff.ale && mux_mode_ff) begin
            ale_addr_ff <= filt_ff.bus;                   // R9 R1
        end
    end

    // Access sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    // Start of a selected strobe
                    if (on && rd) begin
                        state_ff <= ST_READ;
                    end else if (on) begin
                        state_ff <= ST_WRITE;
                    end
                end
                ST_READ, ST_WRITE: begin
                    // Strobe release or deselect ends it
                    if (!on) begin
                        state_ff <= ST_IDLE;              // R6
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Requests: read at strobe start, write at strobe end
    // Writes wait for the end so data has settled on the lines
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_valid_ff <= 1'b0;
            req_ff       <= '0;
        end else begin
            req_valid_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (on && rd) begin
                        req_valid_ff <= 1'b1;             // R5 R7
                        req_ff       <= '{write: 1'b0, addr: cur_addr,
                                          wdata: 8'h00};
                    end else if (on) begin
                        req_ff       <= '{write: 1'b1, addr: cur_addr,
                                          wdata: filt_ff.bus};
                    end
                end
                ST_WRITE: begin
                    if (on) begin
                        req_ff.wdata <= filt_ff.bus;      // R2
                    end else if (!filt_ff.cs_n) begin
                        // Strobe rose while selected: commit
                        req_valid_ff <= 1'b1;             // R6 R7
                    end
                    // Deselect first: write dropped
                end
                default: begin
                    req_valid_ff <= 1'b0;
                end
            endcase
        end
    end

    // Read data out, only while a read access lasts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_oe_ff  <= 1'b0;
            bus_out_ff <= 8'h00;
        end else if (state_ff != ST_READ || !on) begin
            bus_oe_ff  <= 1'b0;                           // R14
        end else if (req_valid_ff) begin
            bus_oe_ff  <= 1'b1;                           // R14
            bus_out_ff <= reg_rdata;
        end
    end

    // Wake flag: set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_flag_ff <= 1'b0;
        end else if (wake_fall && term_fn_en) begin
            wake_flag_ff <= 1'b1;                         // R13
        end else if (wake_flag_clear) begin
            wake_flag_ff <= 1'b0;
        end
    end

    // Open-drain interrupt: enable pulls the line low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_oe_ff <= 1'b0;
        end else begin
            irq_oe_ff <= irq_pending || wake_flag_ff;     // R8
        end
    end

    // Reset pulse driven out after a wake edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_cnt_ff <= '0;
        end else if (wake_fall && term_fn_en && rst_out_en) begin
            rst_cnt_ff <= `RST_CNT_W'(RST_PULSE_CYCLES);  // R12 R13
        end else if (rst_cnt_ff != '0) begin
            rst_cnt_ff <= rst_cnt_ff - `RST_CNT_W'(1);
        end
    end

    assign mux_bus_lines_o  = bus_out_ff;
    assign mux_bus_lines_oe = bus_oe_ff;
    assign irq_n_o          = 1'b0;
    assign irq_n_oe         = irq_oe_ff;
    assign rst_line_o       = 1'b1;
    assign rst_line_oe      = (rst_cnt_ff != '0);
    assign wake_flag        = wake_flag_ff;
    assign reg_req_valid    = req_valid_ff;
    assign reg_req          = req_ff;
    assign mux_mode         = mux_mode_ff;

    // Sequences for the checks below
    sequence seq_rd_start;
        state_ff == ST_IDLE && on && rd;
    endsequence

    sequence seq_wr_end;
        state_ff == ST_WRITE && !on && !filt_ff.cs_n;
    endsequence

    sequence seq_wake_rst;
        wake_fall && term_fn_en && rst_out_en;
    endsequence

    a_cs_ignored: assert property (@(posedge clk) disable iff (rst) // R4
        filt_ff.cs_n |=> !req_valid_ff)
        else $error("request while deselected");

    a_rw_read: assert property (@(posedge clk) disable iff (rst) // R5
        (!sep_strobes and seq_rd_start) |=> req_valid_ff && !req_ff.write)
        else $error("combined read not issued");

    a_write_end: assert property (@(posedge clk) disable iff (rst) // R6
        seq_wr_end |=> req_valid_ff && req_ff.write
                       && req_ff.wdata == $past(filt_ff.bus, 2))
        else $error("write not issued at strobe end");

    a_sep_dir: assert property (@(posedge clk) disable iff (rst) // R7
        sep_strobes && state_ff == ST_IDLE && on && !filt_ff.rw
        && filt_ff.ds |=> state_ff == ST_WRITE && !req_valid_ff)
        else $error("write strobe not decoded");

    a_irq_drive: assert property (@(posedge clk) disable iff (rst) // R8
        irq_pending |=> irq_n_oe && !irq_n_o)
        else $error("interrupt not driven low");

    a_mux_addr: assert property (@(posedge clk) disable iff (rst) // R9
        mux_mode_ff && filt_ff.ale ##1 (!filt_ff.ale)[*2]
        |-> ale_addr_ff == $past(filt_ff.bus, 2))
        else $error("address phase not captured");

    a_nomux_addr: assert property (@(posedge clk) disable iff (rst) // R3
        (!mux_mode_ff and seq_rd_start)
        |=> req_ff.addr == {2'h0, $past(filt_ff.addr)})
        else $error("low address lines not used");

    a_mode_sel: assert property (@(posedge clk) disable iff (rst) // R10
        filt_ff.ale && !ale_d_ff |=> mux_mode_ff)
        else $error("latch strobe did not select mode");

    a_wake_pulse: assert property (@(posedge clk) disable iff (rst) // R13
        seq_wake_rst |=> rst_line_oe && wake_flag_ff ##1 rst_line_oe)
        else $error("wake edge gave no reset pulse");

    a_bus_oe: assert property (@(posedge clk) disable iff (rst) // R14
        mux_bus_lines_oe |-> state_ff == ST_READ)
        else $error("data lines driven outside a read");

endmodule

/* tb/host_cpu_model.sv */
`timescale 1ns/10ps
// Processor on the far side of the shared bus
module host_cpu_model (
    input  wire logic       clk,
    input  wire logic       sep,
    output      logic       cs_n,
    output      logic       rw,
    output      logic       strobe_n,
    output      logic       ale,
    output      logic [5:0] addr,
    output      logic [7:0] bus
);
    logic       drv;   // Processor owns the lines
    logic [7:0] val;   // Value placed on the lines
    logic       tog;   // Alternates while released

    // Released lines never keep the last value
    assign bus = drv ? val : (tog ? ~val : val ^ 8'hA5);

    // Idle levels at time zero
    initial begin
        cs_n = 1'b1;
        rw = 1'b1;
        strobe_n = 1'b1;
        ale = 1'b0;
        addr = 6'h00;
        drv = 1'b0;
        val = 8'h00;
        tog = 1'b0;
    end

    // Pattern source for released lines
    always @(negedge clk) begin
        tog <= ~tog;
    end

    // One whole access; long holds cover the pin filter
    task acc(input logic mux, input logic wr, input logic sel,
             input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        if (mux) begin
            drv <= 1'b1;
            val <= a;
            ale <= 1'b1;
            repeat (6) @(negedge clk);
            ale <= 1'b0;
            repeat (4) @(negedge clk);
            drv <= 1'b0;
        end
        addr <= a[5:0];
        cs_n <= ~sel;
        rw <= ~(wr & ~sep);
        @(negedge clk);
        drv <= wr;
        val <= d;
        // Separate style writes strobe the write line
        if (sep && wr) begin
            rw <= 1'b0;
        end else begin
            strobe_n <= 1'b0;
        end
        repeat (10) @(negedge clk);
        strobe_n <= 1'b1;
        if (sep) begin
            rw <= 1'b1;
        end
        // Select held until the strobe end is seen
        repeat (5) @(negedge clk);
        cs_n <= 1'b1;
        drv <= 1'b0;
        rw <= 1'b1;
        @(negedge clk);
    endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
module tb
    import host_bus_port_pkg::*;
;
    logic       clk, rst, sep, cs_n, rw, ds, ale;
    logic [7:0] cpu_bus, dut_o, bus_i, rdata;
    logic [5:0] addr;
    logic       dut_oe, irq_n_o, irq_n_oe, irq_pending, wake, wake_clr;
    logic       wake_flag, term_en, rout_en, rst_o, rst_oe, rq_v, mux_mode;
    req_t       rq;
    int         err_count, n_compared;

    // Device drive wins only while it reads out
    assign bus_i = dut_oe ? dut_o : cpu_bus;

    host_cpu_model i_host_cpu_model (.clk(clk), .sep(sep), .cs_n(cs_n),
        .rw(rw), .strobe_n(ds), .ale(ale), .addr(addr), .bus(cpu_bus));

    subscriber_ctrl_host_bus_port #(.RST_PULSE_CYCLES(8))
        i_subscriber_ctrl_host_bus_port (.clk(clk), .rst(rst),
        .sep_strobes(sep), .cs_n(cs_n), .rw_or_wr_n(rw),
        .access_end_strobe(ds), .ale(ale), .mux_bus_lines_i(bus_i),
        .mux_bus_lines_o(dut_o), .mux_bus_lines_oe(dut_oe),
        .low_addr_lines(addr), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
        .irq_pending(irq_pending), .wake_input(wake),
        .wake_flag_clear(wake_clr), .wake_flag(wake_flag),
        .term_fn_en(term_en), .rst_out_en(rout_en), .rst_line_o(rst_o),
        .rst_line_oe(rst_oe), .reg_req_valid(rq_v), .reg_req(rq),
        .reg_rdata(rdata), .mux_mode(mux_mode));

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Count and report one comparison
    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task complete_run;
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watch the core side for one access window
    task watch(input logic sel, input logic wr, input logic [7:0] a,
               input logic [7:0] d);
        int         nreq, noe;
        req_t       got;
        logic [7:0] got_o;
        nreq = 0;
        noe = 0;
        got = '0;
        got_o = 8'h00;
        repeat (40) begin
            @(negedge clk);
            if (rq_v === 1'b1) begin
                nreq++;
                got = rq;
            end
            if (dut_oe === 1'b1) begin
                noe++;
                got_o = dut_o;
            end
        end
        chk(nreq == int'(sel), "request count");
        if (sel) begin
            chk(got.write === wr && got.addr === a, "request kind");
            chk(!wr || got.wdata === d, "write data");
            chk(wr ? noe == 0 : noe > 0, "bus drive");
            chk(wr || got_o === (a ^ 8'h5A), "read data");
        end else begin
            chk(noe == 0, "drive unselected");
        end
    endtask

    // Processor access and core-side check in parallel
    task xfer(input logic mux, input logic sel, input logic wr,
              input logic [7:0] a, input logic [7:0] d);
        rdata = a ^ 8'h5A;
        fork
            i_host_cpu_model.acc(mux, wr, sel, a, d);
            watch(sel, wr, mux ? a : {2'b00, a[5:0]}, d);
        join
    endtask

    // Combined strobe, non-multiplexed, top address
    task t_combined;
        @(negedge clk);
        sep = 1'b0;
        xfer(1'b0, 1'b1, 1'b1, 8'h2A, 8'hC3);
        xfer(1'b0, 1'b1, 1'b0, 8'h3F, 8'h00);
        chk(mux_mode === 1'b0, "static latch strobe");
    endtask

    // Separate read and write strobes
    task t_separate;
        @(negedge clk);
        sep = 1'b1;
        xfer(1'b0, 1'b1, 1'b1, 8'h15, 8'h96);
        xfer(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
    endtask

    // Strobes with chip select high
    task t_unselected;
        xfer(1'b0, 1'b0, 1'b1, 8'h11, 8'h22);
        xfer(1'b0, 1'b0, 1'b0, 8'h11, 8'h00);
    endtask

    // Multiplexed accesses, both strobe styles
    task t_mux;
        @(negedge clk);
        sep = 1'b0;
        xfer(1'b1, 1'b1, 1'b1, 8'hC5, 8'h3A);
        xfer(1'b1, 1'b1, 1'b0, 8'hC5, 8'h00);
        chk(mux_mode === 1'b1, "latch strobe pulse");
        sep = 1'b1;
        xfer(1'b1, 1'b1, 1'b0, 8'hFF, 8'h00);
    endtask

    // Pending interrupt pulls the line low
    task t_irq;
        @(negedge clk);
        irq_pending = 1'b1;
        repeat (3) @(negedge clk);
        chk(irq_n_oe === 1'b1 && irq_n_o === 1'b0, "irq on");
        irq_pending = 1'b0;
        repeat (3) @(negedge clk);
        chk(irq_n_oe === 1'b0, "irq off");
    endtask

    // Wake falling edge with functions on or off
    task t_wake(input logic en);
        int n;
        n = 0;
        @(negedge clk);
        term_en = en;
        rout_en = en;
        wake = 1'b0;
        repeat (30) begin
            @(negedge clk);
            if (rst_oe === 1'b1 && rst_o === 1'b1) n++;
        end
        chk(wake_flag === en && irq_n_oe === en, "wake flag");
        chk(n == (en ? 8 : 0), "reset pulse");
        wake_clr = 1'b1;
        @(negedge clk);
        wake_clr = 1'b0;
        wake = 1'b1;
        repeat (3) @(negedge clk);
        chk(wake_flag === 1'b0 && irq_n_oe === 1'b0, "wake clear");
    endtask

    // Reset in mid-run clears mode and drives
    task t_reset;
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        chk(mux_mode === 1'b0 && dut_oe === 1'b0 && rq_v === 1'b0
            && rst_oe === 1'b0, "reset state");
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(wake_flag === 1'b0 && rst_oe === 1'b0 && rq_v === 1'b0,
            "false event after reset");
    endtask

    // Main sequence
    initial begin
        err_count = 0;
        n_compared = 0;
        rst = 1'b1;
        sep = 1'b0;
        rdata = 8'h00;
        irq_pending = 1'b0;
        wake = 1'b1;
        wake_clr = 1'b0;
        term_en = 1'b0;
        rout_en = 1'b0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_combined;
        t_separate;
        t_unselected;
        t_irq;
        t_wake(1'b0);
        t_wake(1'b1);
        t_mux;
        t_reset;
        t_combined;
        complete_run;
    end

    // Watchdog well past the expected run
    initial begin
        #20000;
        err_count++;
        complete_run;
    end
endmodule
